//--- flash_sec_pkg.sv
// Shared constants and types for the flash backdoor unsecure logic.
package flash_sec_pkg;

  // Register port widths and key count.
  localparam int DW = 16;
  localparam int AW = 4;
  localparam int NUM_KEYS = 4;

  // Register offsets.
  localparam logic [AW-1:0] OFS_CTRL = 4'h0;
  localparam logic [AW-1:0] OFS_KEY0 = 4'h1;
  localparam logic [AW-1:0] OFS_KEY1 = 4'h2;
  localparam logic [AW-1:0] OFS_KEY2 = 4'h3;
  localparam logic [AW-1:0] OFS_KEY3 = 4'h4;
  localparam logic [AW-1:0] OFS_STAT = 4'h5;
  localparam logic [AW-1:0] OFS_CLKDIV = 4'h6;
  localparam logic [AW-1:0] OFS_PROT = 4'h7;
  localparam logic [AW-1:0] OFS_INT_STAT = 4'h8;
  localparam logic [AW-1:0] OFS_INT_MASK = 4'h9;

  // Field positions.
  localparam int CTRL_START_BIT = 0;
  localparam int ST_SEC_LSB = 0;
  localparam int ST_KEYEN_LSB = 2;
  localparam int ST_COMMAND_COMPLETE_FLAG_BIT = 4;
  localparam int ST_LOCK_BIT = 5;
  localparam int ST_BUSY_BIT = 6;
  localparam int ST_ACCERR_BIT = 7;
  localparam int SECB_SEC_LSB = 0;
  localparam int SECB_KEYEN_LSB = 6;

  // Interrupt status bits.
  localparam int INT_W = 4;
  localparam int INT_PASS = 0;
  localparam int INT_FAIL = 1;
  localparam int INT_ACCERR = 2;
  localparam int INT_ERASE_UNSEC = 3;

  // Encodings and reset values.
  localparam logic [1:0] SEC_UNSECURE = 2'h2;
  localparam logic [1:0] SEC_RST = 2'h3;
  localparam logic [1:0] KEYEN_ENABLED = 2'h2;
  localparam logic [1:0] KEYEN_RST = 2'h0;
  localparam logic [DW-1:0] KEY_ALL_ZERO = 16'h0000;
  localparam logic [DW-1:0] KEY_ALL_ONE = 16'hFFFF;
  localparam logic [7:0] CLKDIV_RST = 8'h00;
  localparam logic [7:0] PROT_RST = 8'hFF;
  localparam logic [INT_W-1:0] INT_MASK_RST = 4'h0;

  // Flash reset sequence length and last key index.
  localparam int CLK_PERIOD_PS = 25000;
  localparam int RST_SEQ_NS = 1000;
  localparam int RST_SEQ_CYC = (RST_SEQ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [5:0] RST_SEQ_LAST = 6'(RST_SEQ_CYC - 1);
  localparam logic [1:0] KEY_IDX_LAST = 2'(NUM_KEYS - 1);

  typedef enum logic [1:0] {
    ST_RSEQ = 2'b10,
    ST_IDLE = 2'b00,
    ST_CMP = 2'b01,
    ST_DONE = 2'b11
  } vstate_e;

endpackage

//--- key_word_check.sv
// One backdoor key word comparison.
`timescale 1ns/1ps
`default_nettype none
module key_word_check
  import flash_sec_pkg::*;
(
  // Presented and stored words.
  input wire logic [DW-1:0] presented,
  input wire logic [DW-1:0] stored,
  // Result.
  output logic ok
);

  // An erased or blank stored word can never open the part.
  assign ok = (presented == stored) && (stored != KEY_ALL_ZERO) && (stored != KEY_ALL_ONE);

endmodule
`default_nettype wire

//--- flash_backdoor_unsecure_logic.sv
// Backdoor key verification and security state control for the flash module.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module flash_backdoor_unsecure_logic
  import flash_sec_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // Register port.
  input wire logic [AW-1:0] ADDR,
  input wire logic [DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DW-1:0] RDATA,
  // Flash configuration field contents.
  input wire logic [DW-1:0] STORED_KEY0,
  input wire logic [DW-1:0] STORED_KEY1,
  input wire logic [DW-1:0] STORED_KEY2,
  input wire logic [DW-1:0] STORED_KEY3,
  input wire logic [7:0] SEC_BYTE,
  // Mass erase status.
  input wire logic SPECIAL_MODE,
  input wire logic PROG_ARRAY_ERASED,
  input wire logic DATA_ARRAY_ERASED,
  // Security and flash control outputs.
  output logic [1:0] SEC_STATE,
  output logic CMD_COMPLETE,
  output logic BLOCK0_READ_INHIBIT,
  output logic KEY_PROG_ALLOW,
  output logic SEC_SECTOR_ERASE_ALLOW,
  output logic [7:0] CLKDIV,
  output logic [7:0] PROT,
  // Interrupt.
  output logic IRQ
);

  typedef struct packed {
    vstate_e st;
    logic [5:0] cnt;
    logic [1:0] idx;
    logic all_ok;
    logic [1:0] sec;
    logic [1:0] keyen;
    logic lock;
    logic accerr;
    logic [NUM_KEYS-1:0][DW-1:0] key;
    logic [7:0] clkdiv;
    logic [7:0] prot;
    logic [INT_W-1:0] ists;
    logic [INT_W-1:0] imask;
    logic [DW-1:0] rdata;
    logic irq;
    logic unsec;
    logic command_complete_flag;
    logic b0_inh;
  } state_s;

  state_s r;
  state_s n;

  logic [NUM_KEYS-1:0][DW-1:0] stored;
  logic [NUM_KEYS-1:0] word_ok;
  logic [INT_W-1:0] ev;
  logic start;
  logic full_erase;

  // The stored keys are only ever read here, never driven back to the array.
  assign stored[0] = STORED_KEY0;
  assign stored[1] = STORED_KEY1;
  assign stored[2] = STORED_KEY2;
  assign stored[3] = STORED_KEY3;

  for (genvar i = 0; i < NUM_KEYS; i++) begin : g_key
    key_word_check u_chk (
      .presented(r.key[i]),
      .stored(stored[i]),
      .ok(word_ok[i])
    );
  end

  assign start = WR && (ADDR == OFS_CTRL) && WDATA[CTRL_START_BIT];
  assign full_erase = SPECIAL_MODE && PROG_ARRAY_ERASED && DATA_ARRAY_ERASED;

  always_comb begin
    n = r;
    ev = '0;
    n.rdata = '0;

    // Read path; data stands in the cycle after the strobe.
    if (RD) begin
      case (ADDR)
        OFS_KEY0: n.rdata = r.key[0];
        OFS_KEY1: n.rdata = r.key[1];
        OFS_KEY2: n.rdata = r.key[2];
        OFS_KEY3: n.rdata = r.key[3];
        OFS_STAT: begin
          n.rdata[ST_SEC_LSB +: 2] = r.sec;
          n.rdata[ST_KEYEN_LSB +: 2] = r.keyen;
          n.rdata[ST_COMMAND_COMPLETE_FLAG_BIT] = r.command_complete_flag;
          n.rdata[ST_LOCK_BIT] = r.lock;
          n.rdata[ST_BUSY_BIT] = r.b0_inh;
          n.rdata[ST_ACCERR_BIT] = r.accerr;
        end
        OFS_CLKDIV: n.rdata[7:0] = r.clkdiv;
        OFS_PROT: n.rdata[7:0] = r.prot;
        OFS_INT_STAT: begin
          n.rdata[INT_W-1:0] = r.ists;
          n.ists = '0;
        end
        OFS_INT_MASK: n.rdata[INT_W-1:0] = r.imask;
        default: n.rdata = '0;
      endcase
    end

    // Write path. Presented keys only change while no command runs.
    if (WR) begin
      case (ADDR)
        OFS_KEY0: if (r.command_complete_flag) n.key[0] = WDATA;
        OFS_KEY1: if (r.command_complete_flag) n.key[1] = WDATA;
        OFS_KEY2: if (r.command_complete_flag) n.key[2] = WDATA;
        OFS_KEY3: if (r.command_complete_flag) n.key[3] = WDATA;
        OFS_STAT: if (WDATA[ST_ACCERR_BIT]) n.accerr = 1'b0;
        OFS_CLKDIV: begin
          // A running command would see its timing base change under it, so such
          // writes are dropped; the reset sequence itself is the one exception.
          if (r.command_complete_flag || (r.st == ST_RSEQ)) begin
            n.clkdiv = WDATA[7:0];
          end
        end
        OFS_PROT: if (r.command_complete_flag) n.prot = WDATA[7:0];
        OFS_INT_MASK: n.imask = WDATA[INT_W-1:0];
        default: n.imask = n.imask;
      endcase
    end

    case (r.st)
      ST_RSEQ: begin
        n.cnt = 6'(r.cnt + 6'h01);
        if (r.cnt == RST_SEQ_LAST) begin
          // Security comes only from the stored byte; earlier unlocks are gone.
          n.sec = SEC_BYTE[SECB_SEC_LSB +: 2];
          n.keyen = SEC_BYTE[SECB_KEYEN_LSB +: 2];
          n.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (start) begin
          if (r.lock || (r.keyen != KEYEN_ENABLED)) begin
            n.accerr = 1'b1;
            ev[INT_ACCERR] = 1'b1;
          end else begin
            n.st = ST_CMP;
            n.idx = 2'h0;
            n.all_ok = 1'b1;
          end
        end
      end
      ST_CMP: begin
        // One word per cycle; all four comparators run, and word_ok[r.idx] picks the one used.
        n.all_ok = r.all_ok && word_ok[r.idx];
        n.idx = 2'(r.idx + 2'h1);
        if (r.idx == KEY_IDX_LAST) begin
          n.st = ST_DONE;
        end
      end
      ST_DONE: begin
        n.st = ST_IDLE;
        if (r.all_ok) begin
          // Only the volatile state moves; stored byte and protection stay as is.
          n.sec = SEC_UNSECURE;
          ev[INT_PASS] = 1'b1;
        end else begin
          // No write clears this; only the asynchronous reset does.
          n.lock = 1'b1;
          ev[INT_FAIL] = 1'b1;
        end
      end
      default: n.st = ST_IDLE;
    endcase

    if ((r.st != ST_RSEQ) && full_erase && (n.sec != SEC_UNSECURE)) begin
      n.sec = SEC_UNSECURE;
      ev[INT_ERASE_UNSEC] = 1'b1;
    end

    // A new event in the clearing cycle still lands.
    n.ists = n.ists | ev;
    n.irq = |(n.ists & n.imask);
    n.unsec = (n.sec == SEC_UNSECURE);
    n.command_complete_flag = (n.st == ST_IDLE);
    n.b0_inh = (n.st == ST_CMP) || (n.st == ST_DONE);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r <= '0;
      r.st <= ST_RSEQ;
      r.sec <= SEC_RST;
      r.keyen <= KEYEN_RST;
      r.clkdiv <= CLKDIV_RST;
      r.prot <= PROT_RST;
      r.imask <= INT_MASK_RST;
    end else begin
      r <= n;
    end
  end

  assign RDATA = r.rdata;
  assign SEC_STATE = r.sec;
  assign CMD_COMPLETE = r.command_complete_flag;
  assign BLOCK0_READ_INHIBIT = r.b0_inh;
  assign KEY_PROG_ALLOW = r.unsec;
  assign SEC_SECTOR_ERASE_ALLOW = r.unsec;
  assign CLKDIV = r.clkdiv;
  assign PROT = r.prot;
  assign IRQ = r.irq;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_pass_unsec;
    (r.st == ST_DONE) && r.all_ok |=> (SEC_STATE == SEC_UNSECURE) && KEY_PROG_ALLOW;
  endproperty
  a_pass_unsec: assert property (p_pass_unsec) else $error("Verify pass did not unsecure.");

  property p_fail_lock;
    (r.st == ST_DONE) && !r.all_ok |=> r.lock && r.ists[INT_FAIL];
  endproperty
  a_fail_lock: assert property (p_fail_lock) else $error("Verify fail did not lock.");

  property p_lock_holds;
    r.lock |=> r.lock;
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("Lockout lifted without reset.");

  property p_locked_refused;
    (r.st == ST_IDLE) && r.lock && start |=> (r.st == ST_IDLE) && r.accerr;
  endproperty
  a_locked_refused: assert property (p_locked_refused) else $error("Locked verify ran.");

  property p_cmp_walk;
    (r.st == ST_IDLE) ##1 (r.st == ST_CMP) |-> (r.st == ST_CMP) [*4] ##1 (r.st == ST_DONE);
  endproperty
  a_cmp_walk: assert property (p_cmp_walk) else $error("Compare did not take four words.");

  property p_block0;
    (r.st == ST_CMP) || (r.st == ST_DONE) |-> BLOCK0_READ_INHIBIT && !CMD_COMPLETE;
  endproperty
  a_block0: assert property (p_block0) else $error("Block 0 readable during verify.");

  property p_blank_key;
    (r.st == ST_CMP) && ((stored[r.idx] == KEY_ALL_ZERO) || (stored[r.idx] == KEY_ALL_ONE))
      |=> !r.all_ok;
  endproperty
  a_blank_key: assert property (p_blank_key) else $error("Blank stored key matched.");

  property p_one_miss;
    (r.st == ST_CMP) && !word_ok[r.idx] |=> ##[0:4] (r.st == ST_DONE) ##1 r.lock;
  endproperty
  a_one_miss: assert property (p_one_miss) else $error("Single word miss not illegal.");

  property p_prot_kept;
    (r.st == ST_CMP) || (r.st == ST_DONE) |=> $stable(PROT);
  endproperty
  a_prot_kept: assert property (p_prot_kept) else $error("Verify touched protection.");

  property p_clkdiv_rseq;
    (r.st == ST_RSEQ) && WR && (ADDR == OFS_CLKDIV) |=> CLKDIV == $past(WDATA[7:0]);
  endproperty
  a_clkdiv_rseq: assert property (p_clkdiv_rseq) else $error("Reset-time divider write lost.");

  property p_clkdiv_busy;
    !CMD_COMPLETE && (r.st != ST_RSEQ) |=> $stable(CLKDIV);
  endproperty
  a_clkdiv_busy: assert property (p_clkdiv_busy) else $error("Divider changed during command.");

  property p_reload;
    (r.st == ST_RSEQ) && (r.cnt == RST_SEQ_LAST) |=> SEC_STATE == $past(SEC_BYTE[1:0]);
  endproperty
  a_reload: assert property (p_reload) else $error("Security not reloaded.");

  property p_erase_unsec;
    (r.st != ST_RSEQ) && full_erase |=> SEC_STATE == SEC_UNSECURE;
  endproperty
  a_erase_unsec: assert property (p_erase_unsec) else $error("Full erase did not unsecure.");

  property p_keyen_off;
    (r.st == ST_IDLE) && start && (r.keyen != KEYEN_ENABLED) |=> (r.st == ST_IDLE) && r.accerr;
  endproperty
  a_keyen_off: assert property (p_keyen_off) else $error("Start ran while disabled.");

  property p_key_prog;
    KEY_PROG_ALLOW == (SEC_STATE == SEC_UNSECURE);
  endproperty
  a_key_prog: assert property (p_key_prog) else $error("Key programming gate wrong.");

  property p_sector_erase;
    SEC_SECTOR_ERASE_ALLOW == (SEC_STATE == SEC_UNSECURE);
  endproperty
  a_sector_erase: assert property (p_sector_erase) else $error("Erase gate wrong.");

  property p_keys_held;
    (r.st == ST_CMP) |=> $stable(r.key);
  endproperty
  a_keys_held: assert property (p_keys_held) else $error("Keys moved during compare.");

  property p_lock_cause;
    $rose(r.lock) |-> ($past(r.st) == ST_DONE) && !$past(r.all_ok);
  endproperty
  a_lock_cause: assert property (p_lock_cause) else $error("Lock without failed verify.");

  property p_fail_sec;
    (r.st == ST_DONE) && !r.all_ok && !full_erase |=> SEC_STATE == $past(SEC_STATE);
  endproperty
  a_fail_sec: assert property (p_fail_sec) else $error("Failed verify moved security.");

  property p_reload_keyen;
    (r.st == ST_RSEQ) && (r.cnt == RST_SEQ_LAST) |=> r.keyen == $past(SEC_BYTE[7:6]);
  endproperty
  a_reload_keyen: assert property (p_reload_keyen) else $error("Key access not reloaded.");

  c_pass: cover property ((r.st == ST_DONE) && r.all_ok);
  c_fail: cover property ((r.st == ST_DONE) && !r.all_ok);
  c_refused: cover property (start && r.lock);
  c_erase: cover property (ev[INT_ERASE_UNSEC]);

endmodule
`default_nettype wire

//--- flash_cfg_model.sv
// Model of the flash configuration field that feeds stored keys and the security byte.
`timescale 1ns/1ps
`default_nettype none
module flash_cfg_model (
  // Content set select.
  input wire logic [1:0] sel,
  // Stored words.
  output logic [15:0] key0,
  output logic [15:0] key1,
  output logic [15:0] key2,
  output logic [15:0] key3,
  output logic [7:0] sec_byte
);
  // Contents are plain levels, since nothing in the verify path may write the array.
  always_comb begin
    key0 = (sel == 2'h1) ? 16'h0000 : 16'h1234;
    key1 = 16'h5678;
    key2 = 16'h9ABC;
    key3 = 16'hDEF0;
    sec_byte = (sel == 2'h2) ? 8'h03 : 8'h83;
  end
endmodule
`default_nettype wire

//--- tb_flash_backdoor_unsecure_logic.sv
// Self-checking testbench for the flash backdoor unsecure logic.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_backdoor_unsecure_logic
  import flash_sec_pkg::*;
;
  logic CLK, RST, WR, RD, SPECIAL_MODE, PROG_ARRAY_ERASED, DATA_ARRAY_ERASED;
  logic [AW-1:0] ADDR;
  logic [DW-1:0] WDATA, RDATA, STORED_KEY0, STORED_KEY1, STORED_KEY2, STORED_KEY3;
  logic [7:0] SEC_BYTE, CLKDIV, PROT;
  logic [1:0] SEC_STATE, cfg_sel;
  logic CMD_COMPLETE, BLOCK0_READ_INHIBIT, KEY_PROG_ALLOW, SEC_SECTOR_ERASE_ALLOW, IRQ;
  int bad_count, tests_run;
  localparam logic [63:0] GOOD = 64'hDEF0_9ABC_5678_1234;

  flash_cfg_model flash_cfg_model_i (.sel(cfg_sel), .key0(STORED_KEY0), .key1(STORED_KEY1),
    .key2(STORED_KEY2), .key3(STORED_KEY3), .sec_byte(SEC_BYTE));

  flash_backdoor_unsecure_logic flash_backdoor_unsecure_logic_i (.CLK(CLK), .RST(RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .STORED_KEY0(STORED_KEY0), .STORED_KEY1(STORED_KEY1), .STORED_KEY2(STORED_KEY2),
    .STORED_KEY3(STORED_KEY3), .SEC_BYTE(SEC_BYTE), .SPECIAL_MODE(SPECIAL_MODE),
    .PROG_ARRAY_ERASED(PROG_ARRAY_ERASED), .DATA_ARRAY_ERASED(DATA_ARRAY_ERASED),
    .SEC_STATE(SEC_STATE), .CMD_COMPLETE(CMD_COMPLETE),
    .BLOCK0_READ_INHIBIT(BLOCK0_READ_INHIBIT), .KEY_PROG_ALLOW(KEY_PROG_ALLOW),
    .SEC_SECTOR_ERASE_ALLOW(SEC_SECTOR_ERASE_ALLOW), .CLKDIV(CLKDIV), .PROT(PROT), .IRQ(IRQ));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (CMD_COMPLETE !== 1'b1 && n < 60) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (n == 60) begin
      bad_count++;
      $display("CHECK FAILED at %0t: command never completed", $time);
      report_and_stop;
    end
  endtask

  // The divider write lands inside the reset sequence, while the complete flag is still low.
  task automatic do_reset(input logic [1:0] s, input logic [1:0] exp_sec);
    @(posedge CLK);
    RST <= 1'b1;
    cfg_sel <= s;
    repeat (3) @(posedge CLK);
    #1;
    chk({14'h0, SEC_STATE}, 16'h0003);
    chk({8'h0, PROT}, 16'h00FF);
    chk({15'h0, IRQ}, 16'h0000);
    @(posedge CLK);
    RST <= 1'b0;
    wr(OFS_CLKDIV, 16'h0055);
    #1;
    chk({15'h0, CMD_COMPLETE}, 16'h0000);
    wait_done;
    chk({8'h0, CLKDIV}, 16'h0055);
    chk({14'h0, SEC_STATE}, {14'h0, exp_sec});
  endtask

  task automatic verify(input logic [63:0] k, input logic run);
    for (int i = 0; i < NUM_KEYS; i++) begin
      wr(OFS_KEY0 + AW'(i), k[16*i +: 16]);
    end
    wr(OFS_CTRL, 16'h0001);
    #1;
    chk({15'h0, BLOCK0_READ_INHIBIT}, {15'h0, run});
    wait_done;
  endtask

  initial begin
    RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = '0;
    WDATA = '0;
    cfg_sel = 2'h0;
    SPECIAL_MODE = 1'b0;
    PROG_ARRAY_ERASED = 1'b0;
    DATA_ARRAY_ERASED = 1'b0;
    bad_count = 0;
    tests_run = 0;
    do_reset(2'h0, 2'h3);
    rd(OFS_INT_MASK, 16'h0000);
    rd(4'hF, 16'h0000);
    wr(OFS_PROT, 16'h00A5);
    verify(GOOD ^ 64'h0001_0000_0000_0000, 1'b1);
    chk({14'h0, SEC_STATE}, 16'h0003);
    chk({15'h0, IRQ}, 16'h0000);
    rd(OFS_STAT, 16'h003B);
    wr(OFS_INT_MASK, 16'h000F);
    #1;
    chk({15'h0, IRQ}, 16'h0001);
    rd(OFS_INT_STAT, 16'h0002);
    @(posedge CLK);
    #1;
    chk({15'h0, IRQ}, 16'h0000);
    verify(GOOD, 1'b0);
    rd(OFS_STAT, 16'h00BB);
    rd(OFS_INT_STAT, 16'h0004);
    wr(OFS_STAT, 16'h0080);
    verify(GOOD, 1'b0);
    chk({14'h0, SEC_STATE}, 16'h0003);
    chk({8'h0, PROT}, 16'h00A5);
    do_reset(2'h0, 2'h3);
    verify(GOOD, 1'b1);
    chk({14'h0, SEC_STATE}, {14'h0, SEC_UNSECURE});
    chk({15'h0, KEY_PROG_ALLOW}, 16'h0001);
    chk({15'h0, SEC_SECTOR_ERASE_ALLOW}, 16'h0001);
    rd(OFS_STAT, 16'h001A);
    wr(OFS_CLKDIV, 16'h00AA);
    rd(OFS_CLKDIV, 16'h00AA);
    rd(OFS_KEY3, 16'hDEF0);
    rd(OFS_PROT, 16'h00FF);
    chk({8'h0, PROT}, 16'h00FF);
    do_reset(2'h0, 2'h3);
    chk({15'h0, KEY_PROG_ALLOW}, 16'h0000);
    do_reset(2'h1, 2'h3);
    verify(64'hDEF0_9ABC_5678_0000, 1'b1);
    chk({14'h0, SEC_STATE}, 16'h0003);
    do_reset(2'h2, 2'h3);
    verify(GOOD, 1'b0);
    rd(OFS_STAT, 16'h0093);
    @(posedge CLK);
    SPECIAL_MODE <= 1'b1;
    PROG_ARRAY_ERASED <= 1'b1;
    DATA_ARRAY_ERASED <= 1'b1;
    repeat (2) @(posedge CLK);
    #1;
    chk({14'h0, SEC_STATE}, 16'h0002);
    rd(OFS_INT_STAT, 16'h000C);
    report_and_stop;
  end
endmodule
`default_nettype wire
